// File: verilog/pmmc_params.svh
/*
 * Constants of the performance monitor mode control block: register byte
 * offsets, reset values, time base tap positions and the threshold scale.
 * Assumes inclusion by bare name from the package; the top module sees its macros through that.
 */
// How it works
// [RULE_01] Mode control writes land only when the bus access is privileged.
// [RULE_02] Reads return register contents and change no field.
// [RULE_03] Global freeze bit stops every counter update.
// [RULE_04] Supervisor freeze stops updates while privilege indicator is zero.
// [RULE_05] Problem-state freeze stops updates while privilege indicator is one.
// [RULE_06] Mark-one freeze stops updates while the process mark bit is one.
// [RULE_07] Mark-zero freeze stops updates while the process mark bit is zero.
// [RULE_08] Master enable gates exception requests and self-clears when one is raised.
// [RULE_09] Freeze-on-exception holds counters while an enabled condition stands; trigger overrides.
// [RULE_10] Two-bit select picks time base bit 63, 55, 51 or 47.
// [RULE_11] Enabled rising edge of selected time base bit requests an exception.
// [RULE_12] Threshold field times eight gives the threshold in cycles.
// [RULE_13] Enabled negative first counter requests an exception.
// [RULE_14] Enabled negative counter two to eight requests an exception.
// [RULE_15] Trigger holds counters two to eight until counter one negative or exception.
// [RULE_16] Counter one selector sits at positions 19-25, counter two at 26-31.
// [RULE_17] Negative condition needs counter top bit and its enable both set.
// [RULE_18] Register bit positions count from the most significant bit as zero.
// [RULE_19] A counter steps on its event only when no freeze or hold applies.
`ifndef PMMC_PARAMS_SVH
`define PMMC_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PMMC_ADDR_W          12
`define PMMC_OFS_MODE_CTL    12'h000
`define PMMC_OFS_IRQ_STATUS  12'h004
`define PMMC_OFS_IRQ_MASK    12'h008
`define PMMC_OFS_CORE_STATE  12'h00C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMMC_MODE_CTL_RST    32'h8000_0000
`define PMMC_IRQ_MASK_RST    4'h0

// ----------------------------------------
// Time base taps, positions in most-significant-first order
// ----------------------------------------
`define PMMC_TB_TAP_00       6'h3F
`define PMMC_TB_TAP_01       6'h37
`define PMMC_TB_TAP_10       6'h33
`define PMMC_TB_TAP_11       6'h2F

// ----------------------------------------
// Misc
// ----------------------------------------
`define PMMC_THRESH_SHIFT    3
`define PMMC_NUM_CNT         8
`define PMMC_HSIZE_WORD      3'h2

`endif

// File: verilog/pmmc_pkg.sv
/*
 * Types of the performance monitor mode control block.
 * Assumes pmmc_params.svh is on the include path.
 */
package pmmc_pkg;
	`include "pmmc_params.svh"

	// ----------------------------------------
	// Mode control register; first member is the register MSB
	// ----------------------------------------
	typedef struct packed {
		logic       global_count_freeze;
		logic       supervisor_count_freeze;
		logic       problem_state_count_freeze;
		logic       mark_one_count_freeze;
		logic       mark_zero_count_freeze;
		logic       monitor_exception_master_enable;
		logic       freeze_on_exception_condition;
		logic [1:0] time_base_bit_select;
		logic       time_base_exception_enable;
		logic [5:0] threshold;
		logic       first_counter_exception_enable;
		logic       other_counters_exception_enable;
		logic       trigger;
		logic [6:0] first_counter_event_select;
		logic [5:0] second_counter_event_select;
	} pmmc_mode_ctl_t;

	// ----------------------------------------
	// Interrupt status / mask layout
	// ----------------------------------------
	typedef struct packed {
		logic other_negative;
		logic first_negative;
		logic time_base;
		logic exc_request;
	} pmmc_irq_t;

	// ----------------------------------------
	// Captured AHB address phase
	// ----------------------------------------
	typedef struct packed {
		logic                     valid;
		logic                     write;
		logic                     priv;
		logic [`PMMC_ADDR_W-1:0]  addr;
	} pmmc_ahb_req_t;

	typedef enum logic [4:0] {
		PMMC_REG_NONE   = 5'b00001,
		PMMC_REG_MODE   = 5'b00010,
		PMMC_REG_STATUS = 5'b00100,
		PMMC_REG_MASK   = 5'b01000,
		PMMC_REG_CORE   = 5'b10000
	} pmmc_reg_t;

endpackage : pmmc_pkg

// File: verilog/pmmc_top.sv
/*
 * Performance monitor mode control: AHB-Lite register slave, counter update
 * gating for eight counters and monitor exception request logic.
 * Assumes core state, events, counter top bits and the time base all come
 * from logic on hclk; the counters themselves live outside this block.
 */
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps

module pmmc_top
	import pmmc_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [3:0]               hprot,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire logic                     privilege_state_indicator,
	input  wire logic                     process_mark_bit,
	input  wire logic [0:63]              time_base,
	input  wire logic [`PMMC_NUM_CNT-1:0] perf_event,
	input  wire logic [`PMMC_NUM_CNT-1:0] counter_msb,
	output logic      [`PMMC_NUM_CNT-1:0] counter_update,
	output logic                          monitor_exception_request,
	output logic      [6:0]               first_counter_event_select,
	output logic      [5:0]               second_counter_event_select,
	output logic      [8:0]               threshold_cycles,
	output logic                          irq
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic pmmc_reg_t reg_decode(input logic [`PMMC_ADDR_W-1:0] a);
		unique case (a)
			`PMMC_OFS_MODE_CTL:   reg_decode = PMMC_REG_MODE;
			`PMMC_OFS_IRQ_STATUS: reg_decode = PMMC_REG_STATUS;
			`PMMC_OFS_IRQ_MASK:   reg_decode = PMMC_REG_MASK;
			`PMMC_OFS_CORE_STATE: reg_decode = PMMC_REG_CORE;
			default:              reg_decode = PMMC_REG_NONE;
		endcase
	endfunction : reg_decode

	function automatic logic tb_tap(input logic [1:0] sel, input logic [0:63] tb);
		unique case (sel)
			2'h0: tb_tap = tb[`PMMC_TB_TAP_00]; // RULE_10
			2'h1: tb_tap = tb[`PMMC_TB_TAP_01];
			2'h2: tb_tap = tb[`PMMC_TB_TAP_10];
			2'h3: tb_tap = tb[`PMMC_TB_TAP_11];
		endcase
	endfunction : tb_tap

	// ----------------------------------------
	// State
	// ----------------------------------------
	pmmc_ahb_req_t  req;
	pmmc_ahb_req_t  next_req;
	logic [31:0]    next_hrdata;
	pmmc_mode_ctl_t mode_ctl;
	pmmc_mode_ctl_t next_mode_ctl;
	pmmc_irq_t      status;
	pmmc_irq_t      next_status;
	pmmc_irq_t      mask;
	pmmc_irq_t      next_mask;
	logic           tb_prev;
	logic           next_tb_prev;
	logic           tb_freeze;
	logic           next_tb_freeze;
	logic [`PMMC_NUM_CNT-1:0] next_counter_update;
	logic           next_exc_request;
	logic           next_irq;

	// ----------------------------------------
	// Gating terms
	// ----------------------------------------
	logic                     sw_write;
	pmmc_reg_t                wr_sel;
	logic                     mode_write;
	logic                     tb_bit;
	logic                     tb_cond;
	logic                     first_neg;
	logic                     other_neg;
	logic                     neg_cond;
	logic                     exc_fire;
	logic                     freeze_on_exception_condition_freeze;
	logic                     freeze_all;
	logic                     trigger_hold;
	logic [`PMMC_NUM_CNT-1:0] allow;

	always_comb begin
		sw_write   = req.valid & req.write;
		wr_sel     = reg_decode(req.addr);
		// Unprivileged writes complete OKAY but leave the register alone
		mode_write = sw_write & (wr_sel == PMMC_REG_MODE) & req.priv; // RULE_01
		tb_bit     = tb_tap(mode_ctl.time_base_bit_select, time_base);
		tb_cond    = tb_bit & ~tb_prev & mode_ctl.time_base_exception_enable; // RULE_11
		first_neg  = counter_msb[0] & mode_ctl.first_counter_exception_enable; // RULE_17
		other_neg  = (|counter_msb[`PMMC_NUM_CNT-1:1]) & mode_ctl.other_counters_exception_enable; // RULE_17
		neg_cond   = first_neg | other_neg;
		exc_fire   = mode_ctl.monitor_exception_master_enable & (tb_cond | neg_cond); // RULE_08 RULE_13 RULE_14
		// Trigger mode lets counter one run on so the trigger can still fire
		freeze_on_exception_condition_freeze = mode_ctl.freeze_on_exception_condition & ~mode_ctl.trigger
			& (neg_cond | tb_freeze); // RULE_09
		freeze_all = mode_ctl.global_count_freeze // RULE_03
			| (mode_ctl.supervisor_count_freeze & ~privilege_state_indicator) // RULE_04
			| (mode_ctl.problem_state_count_freeze & privilege_state_indicator) // RULE_05
			| (mode_ctl.mark_one_count_freeze & process_mark_bit) // RULE_06
			| (mode_ctl.mark_zero_count_freeze & ~process_mark_bit) // RULE_07
			| freeze_on_exception_condition_freeze;
		trigger_hold = mode_ctl.trigger & ~counter_msb[0]
			& mode_ctl.monitor_exception_master_enable; // RULE_15
	end

	// ----------------------------------------
	// Per-counter update enables
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `PMMC_NUM_CNT; gi++) begin : g_allow
			if (gi == 0) begin : g_first
				assign allow[gi] = ~freeze_all;
			end else begin : g_other
				assign allow[gi] = ~freeze_all & ~trigger_hold; // RULE_15
			end
		end
	endgenerate

	// ----------------------------------------
	// Register and gating next state
	// ----------------------------------------
	always_comb begin
		next_mode_ctl  = mode_ctl;
		next_status    = status;
		next_mask      = mask;
		next_tb_freeze = tb_freeze;
		next_tb_prev   = tb_bit;
		if (mode_write) begin
			next_mode_ctl  = pmmc_mode_ctl_t'(hwdata); // RULE_18 RULE_16
			next_tb_freeze = 1'b0;
		end
		// Hardware clear beats a simultaneous software write of the enable
		if (exc_fire) begin
			next_mode_ctl.monitor_exception_master_enable = 1'b0; // RULE_08
		end
		if (tb_cond) begin
			next_tb_freeze = 1'b1; // RULE_09
		end
		if (sw_write && wr_sel == PMMC_REG_STATUS) begin
			next_status = pmmc_irq_t'(status & ~hwdata[3:0]);
		end
		if (sw_write && wr_sel == PMMC_REG_MASK) begin
			next_mask = pmmc_irq_t'(hwdata[3:0]);
		end
		// Set wins over a write-one-to-clear in the same cycle
		next_status.exc_request    = next_status.exc_request | exc_fire;
		next_status.time_base      = next_status.time_base | tb_cond;
		next_status.first_negative = next_status.first_negative | first_neg;
		next_status.other_negative = next_status.other_negative | other_neg;
		next_counter_update = perf_event & allow; // RULE_19
		next_exc_request    = exc_fire;
		next_irq            = |(next_status & next_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ctl                  <= pmmc_mode_ctl_t'(`PMMC_MODE_CTL_RST);
			status                    <= pmmc_irq_t'(4'h0);
			mask                      <= pmmc_irq_t'(`PMMC_IRQ_MASK_RST);
			tb_freeze                 <= 1'b0;
			tb_prev                   <= 1'b0;
			counter_update            <= '0;
			monitor_exception_request <= 1'b0;
			irq                       <= 1'b0;
		end else begin
			mode_ctl                  <= next_mode_ctl;
			status                    <= next_status;
			mask                      <= next_mask;
			tb_freeze                 <= next_tb_freeze;
			tb_prev                   <= next_tb_prev;
			counter_update            <= next_counter_update;
			monitor_exception_request <= next_exc_request;
			irq                       <= next_irq;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------
	// Read data is taken from next-state values so a read right after a
	// write returns the freshly written contents.
	always_comb begin
		next_req.valid = hsel & htrans[1] & hready;
		next_req.write = hwrite & (hsize == `PMMC_HSIZE_WORD);
		next_req.priv  = hprot[1];
		next_req.addr  = haddr[`PMMC_ADDR_W-1:0];
		next_hrdata    = 32'h0000_0000;
		if (next_req.valid && !hwrite) begin
			unique case (reg_decode(haddr[`PMMC_ADDR_W-1:0]))
				PMMC_REG_MODE:   next_hrdata = next_mode_ctl; // RULE_02
				PMMC_REG_STATUS: next_hrdata = {28'h000_0000, next_status};
				PMMC_REG_MASK:   next_hrdata = {28'h000_0000, next_mask};
				PMMC_REG_CORE:   next_hrdata = {27'h000_0000, trigger_hold, freeze_on_exception_condition_freeze,
					freeze_all, privilege_state_indicator, process_mark_bit};
				PMMC_REG_NONE:   next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req       <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			req       <= next_req;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Field outputs straight from the mode register
	// ----------------------------------------
	assign first_counter_event_select  = mode_ctl.first_counter_event_select; // RULE_16
	assign second_counter_event_select = mode_ctl.second_counter_event_select; // RULE_16
	assign threshold_cycles            = {mode_ctl.threshold, 3'h0}; // RULE_12

endmodule : pmmc_top

// File: testbench/pmmc_top_asserts.sv
/*
 * Checker for pmmc_top: shadows the mode control word from bus writes and checks
 * counter gating, exception requests and field outputs against it.
 * Assumes word writes only and hready tied to hreadyout.
 */
`timescale 1ns/100ps

module pmmc_top_asserts
	import pmmc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [3:0]  hprot,
	input wire logic [31:0] hwdata,
	input wire logic        privilege_state_indicator,
	input wire logic        process_mark_bit,
	input wire logic [0:63] time_base,
	input wire logic [7:0]  perf_event,
	input wire logic [7:0]  counter_msb,
	input wire logic [7:0]  counter_update,
	input wire logic        monitor_exception_request,
	input wire logic [6:0]  first_counter_event_select,
	input wire logic [5:0]  second_counter_event_select,
	input wire logic [8:0]  threshold_cycles
);
	// ------
	// Shadow of the mode control word
	// ------
	localparam logic [5:0] taps [4] = '{6'h3F, 6'h37, 6'h33, 6'h2F};
	pmmc_mode_ctl_t mc;
	logic           wr;
	logic           en;
	logic           tap;

	// The shadow sees the hardware clear one cycle late, so mask it while the request stands
	assign en = mc.monitor_exception_master_enable && !monitor_exception_request;
	assign tap = time_base[taps[mc.time_base_bit_select]];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr <= 1'b0;
			mc <= `PMMC_MODE_CTL_RST;
		end else begin
			wr <= hsel && htrans[1] && hwrite && hprot[1] && haddr[11:0] == `PMMC_OFS_MODE_CTL;
			if (wr)
				mc <= hwdata;
			if (monitor_exception_request)
				mc.monitor_exception_master_enable <= 1'b0;
		end
	end

	// ------
	// Properties
	// ------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_global_freeze: assert property ($past(mc.global_count_freeze) |-> counter_update == 8'h00)
		else $error("update under global freeze");
	a_privilege_freeze: assert property ($past(mc.supervisor_count_freeze && !privilege_state_indicator
		|| mc.problem_state_count_freeze && privilege_state_indicator) |-> counter_update == 8'h00)
		else $error("update under privilege freeze");
	a_mark_freeze: assert property ($past(mc.mark_one_count_freeze && process_mark_bit
		|| mc.mark_zero_count_freeze && !process_mark_bit) |-> counter_update == 8'h00)
		else $error("update under mark freeze");
	a_update_needs_event: assert property ((counter_update & ~$past(perf_event)) == 8'h00)
		else $error("update without event");
	a_trigger_hold: assert property ($past(mc.trigger && !counter_msb[0] && en) |-> counter_update[7:1] == 7'h00)
		else $error("counters two to eight moved under trigger");
	a_request_gated: assert property (monitor_exception_request |-> $past(en))
		else $error("request without master enable");
	a_time_base_rise: assert property (en && mc.time_base_exception_enable && $rose(tap)
		&& $stable(mc.time_base_bit_select) |=> monitor_exception_request)
		else $error("time base rise not requested");
	a_negative_request: assert property (en && (mc.first_counter_exception_enable && counter_msb[0]
		|| mc.other_counters_exception_enable && |counter_msb[7:1]) |=> monitor_exception_request)
		else $error("negative counter not requested");
	a_exception_freeze: assert property ($past(mc.freeze_on_exception_condition && !mc.trigger
		&& (mc.first_counter_exception_enable && counter_msb[0]
		|| mc.other_counters_exception_enable && |counter_msb[7:1])) |-> counter_update == 8'h00)
		else $error("update under freeze on exception");
	a_field_outputs: assert property (threshold_cycles == {mc.threshold, 3'h0}
		&& first_counter_event_select == mc.first_counter_event_select
		&& second_counter_event_select == mc.second_counter_event_select)
		else $error("field outputs differ from written word");
endmodule : pmmc_top_asserts

bind pmmc_top pmmc_top_asserts pmmc_top_asserts_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hprot, .hwdata,
	.privilege_state_indicator, .process_mark_bit, .time_base, .perf_event, .counter_msb, .counter_update,
	.monitor_exception_request, .first_counter_event_select, .second_counter_event_select, .threshold_cycles);

// File: testbench/pmmc_core_model.sv
/*
 * Core side model: the time base and the eight event counters that the block gates.
 * Assumes the bench sets the time base step and clears the counters.
 */
`timescale 1ns/100ps

module pmmc_core_model
	import pmmc_pkg::*;
#(
	parameter int CW = 4
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clr,
	input  wire logic [63:0] tb_inc,
	input  wire logic [7:0]  counter_update,
	output logic      [7:0]  counter_msb,
	output logic      [0:63] time_base
);
	// Short counters turn negative after a few events, trading width for run time
	logic [CW-1:0] cnt [8];
	logic [63:0]   tb;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tb <= 64'h0;
			for (int i = 0; i < 8; i++)
				cnt[i] <= '0;
		end else begin
			tb <= tb + tb_inc;
			for (int i = 0; i < 8; i++)
				cnt[i] <= clr ? '0 : cnt[i] + CW'(counter_update[i]);
		end
	end

	always_comb begin
		for (int i = 0; i < 8; i++)
			counter_msb[i] = cnt[i][CW-1];
	end
	assign time_base = tb;
endmodule : pmmc_core_model

// File: testbench/pmmc_top_bench.sv
/*
 * Testbench of pmmc_top: AHB-Lite register access, counter gating and exception requests.
 * Assumes the core model stands in for the counters and the time base.
 */
`timescale 1ns/100ps

module pmmc_top_bench;
	import pmmc_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [3:0]  hprot = 4'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        privilege_state_indicator = 1'b0;
	logic        process_mark_bit = 1'b0;
	logic [0:63] time_base;
	logic [7:0]  perf_event = 8'h00;
	logic [7:0]  counter_msb;
	logic [7:0]  counter_update;
	logic        monitor_exception_request;
	logic [6:0]  first_counter_event_select;
	logic [5:0]  second_counter_event_select;
	logic [8:0]  threshold_cycles;
	logic        irq;
	logic        clr = 1'b0;
	logic [63:0] tb_inc = 64'h0;
	logic [31:0] rd;
	logic [31:0] v = 32'h0015_A5C3;
	int          fails = 0;
	int          total_checks = 0;
	logic [31:0] fm [10] = '{32'h0, 32'h8000_0000, 32'h4000_0000, 32'h4000_0000, 32'h2000_0000,
		32'h2000_0000, 32'h1000_0000, 32'h1000_0000, 32'h0800_0000, 32'h0800_0000};
	logic [1:0]  fs [10] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1};
	logic [7:0]  fe [10] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF};

	always #12.5 hclk = ~hclk;

	pmmc_top pmmc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .privilege_state_indicator, .process_mark_bit,
		.time_base, .perf_event, .counter_msb, .counter_update, .monitor_exception_request,
		.first_counter_event_select, .second_counter_event_select, .threshold_cycles, .irq);
	pmmc_core_model pmmc_core_model_i (.hclk, .hresetn, .clr, .tb_inc, .counter_update, .counter_msb, .time_base);

	// ------
	// Tasks
	// ------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Values are sampled half a cycle before the edge that takes them, so no race with the design
	task automatic bus(input logic [11:0] a, input logic w, input logic p, input logic [31:0] d);
		logic rdy;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hprot <= {2'h0, p, 1'b1};
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			@(posedge hclk);
		end while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask : bus

	task automatic ev(input logic [7:0] exp);
		@(posedge hclk);
		perf_event <= 8'hFF;
		@(posedge hclk);
		perf_event <= 8'h00;
		@(negedge hclk);
		chk(counter_update, exp);
	endtask : ev

	task automatic wait_req;
		logic seen;
		seen = 1'b0;
		repeat (20) begin
			@(negedge hclk);
			seen = seen | (monitor_exception_request === 1'b1);
		end
		chk(seen, 1'b1);
	endtask : wait_req

	task automatic clear_counters;
		@(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
	endtask : clear_counters

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// ------
	// Tests
	// ------
	initial begin
		#125000;
		fails++;
		end_of_test;
	end

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus(`PMMC_OFS_MODE_CTL, 1'b0, 1'b1, 32'h0);
		chk(rd, `PMMC_MODE_CTL_RST);
		bus(12'h010, 1'b0, 1'b1, 32'h0);
		chk(rd, 32'h0);
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, v);
		// Field outputs are launched by the edge that ends the write, so wait until they settle
		@(negedge hclk);
		chk(threshold_cycles, {v[21:16], 3'h0});
		chk(first_counter_event_select, v[12:6]);
		chk(second_counter_event_select, v[5:0]);
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b0, ~v);
		bus(`PMMC_OFS_MODE_CTL, 1'b0, 1'b1, 32'h0);
		chk(rd, v);
		bus(`PMMC_OFS_MODE_CTL, 1'b0, 1'b1, 32'h0);
		chk(rd, v);
		chk({hreadyout, hresp}, 32'h2);
		for (int i = 0; i < 10; i++) begin
			bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, fm[i]);
			@(posedge hclk);
			{privilege_state_indicator, process_mark_bit} <= fs[i];
			ev(fe[i]);
		end
		clear_counters;
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h0400_2000);
		bus(`PMMC_OFS_CORE_STATE, 1'b0, 1'b1, 32'h0);
		chk(rd, 32'h0000_0011);
		repeat (8) ev(8'h01);
		ev(8'hFF);
		clear_counters;
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h0400_8000);
		repeat (8) ev(8'hFF);
		wait_req;
		// Counter one stays negative: freeze on exception holds all, trigger lifts it
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h0200_8000);
		ev(8'h00);
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h0200_A000);
		ev(8'hFF);
		bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h0400_4000);
		wait_req;
		for (int s = 0; s < 4; s++) begin
			@(posedge hclk);
			tb_inc <= 64'h1 << (s == 0 ? 0 : 4 * s + 4);
			bus(`PMMC_OFS_MODE_CTL, 1'b1, 1'b1, 32'h8440_0000 | (s << 23));
			wait_req;
			bus(`PMMC_OFS_MODE_CTL, 1'b0, 1'b1, 32'h0);
			chk(rd[26], 1'b0);
		end
		tb_inc <= 64'h0;
		chk(irq, 1'b0);
		bus(`PMMC_OFS_IRQ_MASK, 1'b1, 1'b0, 32'h1);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b1);
		bus(`PMMC_OFS_IRQ_STATUS, 1'b1, 1'b0, 32'h1);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b0);
		end_of_test;
	end
endmodule : pmmc_top_bench
